/* core/eft_exposure_frame.v */
// eft_exposure_frame.v: exposure (shutter) agc, frame timer and their byte registers
// assumes: a serial port engine upstream issues one-cycle register read/write strobes
// on clk_i; the pixel array supplies per-frame max/average and pixel samples.
// Behaviour
// - pixel values reported as 0 to 63
// - agc keeps brightest pixel in mid 50s
// - shutter read-only word at 0x0e/0x0f
// - shutter counts clocks, resets to 0x0064
// - agc steps shutter at most once per frame; a shorter frame caps it at once
// - shutter step is one sixteenth of value
// - shutter capped at frame cycles minus 2816
// - frame period rw twos complement, reset 0xD120
// - frame timer counts up from period to overflow
// - dump byte msb high marks invalid data
`timescale 1ns/10ps
`include "eft_map.vh"

module eft_exposure_frame (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire [6:0]  reg_addr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  output wire        reg_hit_o,
  input  wire [5:0]  frame_max_pix_i,
  input  wire [5:0]  frame_avg_pix_i,
  input  wire        frame_stats_vld_i,
  input  wire [6:0]  pix_raw_i,
  input  wire        pix_raw_vld_i,
  output reg  [7:0]  dump_data_o,
  output reg         frame_end_o,
  output wire [15:0] exposure_o
);

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  reg  [15:0] exposure_reg;
  reg  [15:0] exposure_next;
  reg  [7:0]  exp_lo_shadow_reg;
  reg  [7:0]  exp_lo_shadow_next;
  reg  [7:0]  frm_lo_stage_reg;
  reg  [7:0]  frm_lo_stage_next;
  reg  [15:0] frm_period_reg;
  reg  [15:0] frm_period_next;
  reg  [15:0] frm_count_reg;
  reg  [15:0] frm_count_next;
  reg         stats_pend_reg;
  reg         stats_pend_next;
  reg  [5:0]  max_pix_reg;
  reg  [5:0]  max_pix_next;
  reg  [5:0]  avg_pix_reg;
  reg  [5:0]  avg_pix_next;
  reg  [7:0]  rdata_next;
  reg  [7:0]  dump_next;

  //--------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------
  wire        sel_exp_lo = (reg_addr_i == `EFT_ADDR_EXP_LO);
  wire        sel_exp_hi = (reg_addr_i == `EFT_ADDR_EXP_HI);
  wire        sel_frm_lo = (reg_addr_i == `EFT_ADDR_FRM_LO);
  wire        sel_frm_hi = (reg_addr_i == `EFT_ADDR_FRM_HI);
  wire        wr_frm_lo  = reg_wr_i & sel_frm_lo;
  wire        wr_frm_hi  = reg_wr_i & sel_frm_hi;
  wire        rd_exp_hi  = reg_rd_i & sel_exp_hi;

  assign reg_hit_o = sel_exp_lo | sel_exp_hi | sel_frm_lo | sel_frm_hi;

  //--------------------------------------------------------------
  // frame geometry
  //--------------------------------------------------------------
  // cycles per frame = 65536 - period; cap = that minus overhead
  wire [16:0] frm_len  = 17'h10000 - {1'b0, frm_period_reg};
  wire        cap_pos  = (frm_len > `EFT_EXP_OVERHEAD);
  wire [16:0] cap_wide = cap_pos ? (frm_len - `EFT_EXP_OVERHEAD) : 17'h00000;
  wire [15:0] exp_cap  = cap_wide[16] ? 16'hFFFF : cap_wide[15:0];
  wire [16:0] frm_inc  = {1'b0, frm_count_reg} + 17'h00001;
  wire        overflow = frm_inc[16];

  //--------------------------------------------------------------
  // agc arithmetic
  //--------------------------------------------------------------
  wire [15:0] step       = exposure_reg >> `EFT_STEP_SHIFT;
  wire [15:0] exp_dn     = exposure_reg - step;
  wire [16:0] exp_up     = {1'b0, exposure_reg} + {1'b0, step};
  wire        too_bright = (max_pix_reg > `EFT_AGC_HIGH) | (avg_pix_reg > `EFT_AVG_HIGH);
  wire        too_dark   = (max_pix_reg < `EFT_AGC_LOW) | (avg_pix_reg < `EFT_AVG_LOW);
  wire        agc_due    = overflow & stats_pend_reg;

  assign exposure_o = exposure_reg;

  //--------------------------------------------------------------
  // agc step decision
  //--------------------------------------------------------------
  always @* begin
    exposure_next = exposure_reg;
    if (agc_due) begin
      if (too_bright) begin
        if (exp_dn >= `EFT_EXP_MIN)
          exposure_next = exp_dn;
      end else if (too_dark) begin
        if (exp_up <= {1'b0, exp_cap})
          exposure_next = exp_up[15:0];
      end
    end
    // a shorter frame pulls the shutter down at once
    if (exposure_next > exp_cap)
      exposure_next = exp_cap;
  end

  //--------------------------------------------------------------
  // frame timer and frame statistics
  //--------------------------------------------------------------
  always @* begin
    if (overflow)
      frm_count_next = frm_period_reg;
    else
      frm_count_next = frm_inc[15:0];
  end

  always @* begin
    max_pix_next    = max_pix_reg;
    avg_pix_next    = avg_pix_reg;
    stats_pend_next = stats_pend_reg;
    if (frame_stats_vld_i) begin
      // stats landing in the closing cycle stay for the next frame
      max_pix_next    = frame_max_pix_i;
      avg_pix_next    = frame_avg_pix_i;
      stats_pend_next = 1'b1;
    end else if (overflow) begin
      stats_pend_next = 1'b0;
    end
  end

  //--------------------------------------------------------------
  // register writes and read shadow
  //--------------------------------------------------------------
  always @* begin
    frm_lo_stage_next  = frm_lo_stage_reg;
    frm_period_next    = frm_period_reg;
    exp_lo_shadow_next = exp_lo_shadow_reg;
    if (wr_frm_lo)
      frm_lo_stage_next = reg_wdata_i;
    if (wr_frm_hi)
      frm_period_next = {reg_wdata_i, frm_lo_stage_reg};
    if (rd_exp_hi)
      exp_lo_shadow_next = exposure_reg[7:0];
  end

  //--------------------------------------------------------------
  // read data
  //--------------------------------------------------------------
  always @* begin
    rdata_next = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `EFT_ADDR_EXP_HI: rdata_next = exposure_reg[15:8];
        `EFT_ADDR_EXP_LO: rdata_next = exp_lo_shadow_reg;
        `EFT_ADDR_FRM_HI: rdata_next = frm_period_reg[15:8];
        `EFT_ADDR_FRM_LO: rdata_next = frm_period_reg[7:0];
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  //--------------------------------------------------------------
  // pixel dump byte: invalid flag plus saturated 6-bit value
  //--------------------------------------------------------------
  wire        pix_over = (pix_raw_i > {1'b0, `EFT_PIX_MAX});
  wire [5:0]  pix_sat  = pix_over ? `EFT_PIX_MAX : pix_raw_i[5:0];

  always @* begin
    dump_next = dump_data_o;
    // a frame end wins over a sample in the same cycle
    if (overflow)
      dump_next[`EFT_INVALID_BIT] = 1'b1;
    else if (pix_raw_vld_i)
      dump_next = {2'b00, pix_sat};
  end

  //--------------------------------------------------------------
  // flip-flops
  //--------------------------------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exposure_reg   <= {`EFT_RST_EXP_HI, `EFT_RST_EXP_LO};
      frm_count_reg  <= {`EFT_RST_FRM_HI, `EFT_RST_FRM_LO};
      stats_pend_reg <= 1'b0;
      max_pix_reg    <= 6'h00;
      avg_pix_reg    <= 6'h00;
    end else begin
      exposure_reg   <= exposure_next;
      frm_count_reg  <= frm_count_next;
      stats_pend_reg <= stats_pend_next;
      max_pix_reg    <= max_pix_next;
      avg_pix_reg    <= avg_pix_next;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frm_period_reg    <= {`EFT_RST_FRM_HI, `EFT_RST_FRM_LO};
      frm_lo_stage_reg  <= `EFT_RST_FRM_LO;
      exp_lo_shadow_reg <= `EFT_RST_EXP_LO;
    end else begin
      frm_period_reg    <= frm_period_next;
      frm_lo_stage_reg  <= frm_lo_stage_next;
      exp_lo_shadow_reg <= exp_lo_shadow_next;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      dump_data_o <= 8'h80;
      frame_end_o <= 1'b0;
    end else begin
      reg_rdata_o <= rdata_next;
      dump_data_o <= dump_next;
      frame_end_o <= overflow;
    end
  end

endmodule

/* core/eft_map.vh */
// eft_map.vh: register offsets, reset values and timing constants of the exposure/frame block
// assumes: included by the block's module file only
`ifndef EFT_MAP_VH
`define EFT_MAP_VH
`define EFT_ADDR_EXP_LO     7'h0E
`define EFT_ADDR_EXP_HI     7'h0F
`define EFT_ADDR_FRM_LO     7'h10
`define EFT_ADDR_FRM_HI     7'h11
`define EFT_RST_EXP_LO      8'h64
`define EFT_RST_EXP_HI      8'h00
`define EFT_RST_FRM_LO      8'h20
`define EFT_RST_FRM_HI      8'hD1
`define EFT_EXP_OVERHEAD    17'h00B00
`define EFT_EXP_MIN         16'h0010
`define EFT_PIX_MAX         6'h3F
`define EFT_AGC_HIGH        6'h39
`define EFT_AGC_LOW         6'h32
`define EFT_AVG_HIGH        6'h30
`define EFT_AVG_LOW         6'h08
`define EFT_STEP_SHIFT      4
`define EFT_INVALID_BIT     7
`endif

/* testbench/eft_exposure_frame_chk.sv */
// checker: port-level assertions of the exposure/frame block
// assumes: bound to every eft_exposure_frame instance
`timescale 1ns/10ps
module eft_exposure_frame_chk (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire        pix_raw_vld_i,
  input wire        frame_end_o,
  input wire [6:0]  reg_addr_i,
  input wire [6:0]  pix_raw_i,
  input wire [7:0]  reg_rdata_o,
  input wire [7:0]  dump_data_o,
  input wire [15:0] exposure_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  miss_zero_a: assert property (reg_rd_i && reg_addr_i > 7'h11 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  high_read_a: assert property (reg_rd_i && reg_addr_i == 7'h0F |=>
    {reg_rdata_o, 8'h00} == ($past(exposure_o) & 16'hFF00)) else $error("bad high byte");
  read_only_a: assert property (reg_wr_i && reg_addr_i[6:1] == 6'h07 ##1 !frame_end_o
    |-> $stable(exposure_o)) else $error("shutter took a write");
  one_frame_a: assert property ($changed(exposure_o) |-> frame_end_o || $past(reg_wr_i)
    || $past(reg_wr_i, 2)) else $error("shutter moved mid frame");
  step_size_a: assert property (frame_end_o && $changed(exposure_o) |->
    (exposure_o - $past(exposure_o)) == ($past(exposure_o) >> 4) ||
    ($past(exposure_o) - exposure_o) == ($past(exposure_o) >> 4)) else $error("bad step");
  pix_range_a: assert property (!dump_data_o[6]) else $error("pixel out of range");
  pix_clip_a: assert property (pix_raw_vld_i && pix_raw_i > 7'h3F ##1 !frame_end_o
    |-> dump_data_o[5:0] == 6'h3F) else $error("pixel not clipped");
  flag_clear_a: assert property (pix_raw_vld_i ##1 !frame_end_o |-> !dump_data_o[7])
    else $error("invalid flag stuck");
  high_c: cover property (reg_rd_i && reg_addr_i == 7'h0F);
  step_c: cover property (frame_end_o && $changed(exposure_o));
  clip_c: cover property (pix_raw_vld_i && pix_raw_i > 7'h3F);
endmodule
bind eft_exposure_frame eft_exposure_frame_chk chk (
  .clk_i         (clk_i),
  .sys_rst_i     (sys_rst_i),
  .reg_wr_i      (reg_wr_i),
  .reg_rd_i      (reg_rd_i),
  .pix_raw_vld_i (pix_raw_vld_i),
  .frame_end_o   (frame_end_o),
  .reg_addr_i    (reg_addr_i),
  .pix_raw_i     (pix_raw_i),
  .reg_rdata_o   (reg_rdata_o),
  .dump_data_o   (dump_data_o),
  .exposure_o    (exposure_o)
);

/* testbench/eft_host.sv */
// partner: host issuing one-cycle register strobes
// assumes: the bench calls acc once per access, in the legal order
`timescale 1ns/10ps
module eft_host (
  input  wire       clk_i,
  output reg  [6:0] addr_o,
  output reg        rd_o,
  output reg        wr_o,
  output reg  [7:0] wdata_o
);
  initial {addr_o, rd_o, wr_o, wdata_o} = 17'h00000;
  // released bus shows inverted address and data with both strobes low, never the last values
  task acc(input r, input [6:0] a, input [7:0] d);
    begin
      @(negedge clk_i) {addr_o, rd_o, wr_o, wdata_o} = {a, r, !r, d};
      @(negedge clk_i) {addr_o, rd_o, wr_o, wdata_o} = {~a, 2'b00, ~d};
    end
  endtask
endmodule

/* testbench/tb_eft_exposure_frame.sv */
// bench: registers, frame timer, agc and pixel dump
// assumes: eft_host and the checker are compiled first
`timescale 1ns/10ps
module tb_eft_exposure_frame;
  reg         clk_i = 1'b0, sys_rst_i = 1'b1, sv = 1'b0, pv = 1'b0, rdd = 1'b0;
  reg  [5:0]  mx = 6'h20, av = 6'h14;
  reg  [6:0]  px = 7'h00;
  reg  [7:0]  q[$];
  wire [6:0]  a;
  wire        rd, wr, fe, hit;
  wire [7:0]  wd, rdat, dd;
  wire [15:0] ex;
  integer     mismatches = 0, compares = 0, seed = 26181, i;
  initial forever #2.5 clk_i = ~clk_i;
  eft_host host (.clk_i(clk_i), .addr_o(a), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  eft_exposure_frame dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(a),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_hit_o(hit),
    .frame_max_pix_i(mx), .frame_avg_pix_i(av), .frame_stats_vld_i(sv), .pix_raw_i(px),
    .pix_raw_vld_i(pv), .dump_data_o(dd), .frame_end_o(fe), .exposure_o(ex));
  task cmp(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task chk(input [6:0] ad, input [7:0] e);
    begin
      q.push_back(e);
      host.acc(1'b1, ad, 8'h00);
    end
  endtask
  // counts cycles until the frame end pulse, then steps past it
  task wfe;
    begin
      for (i = 0; fe !== 1'b1 && i < 20000; i = i + 1) @(negedge clk_i);
      if (fe !== 1'b1) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t frame end missing", $time);
      end
      @(negedge clk_i);
    end
  endtask
  task agc(input [5:0] m, input [5:0] v, input [7:0] e);
    begin
      mx = m;
      av = v;
      sv = 1'b1;
      @(negedge clk_i) sv = 1'b0;
      wfe;
      cmp(ex[7:0], e);
      chk(7'h0F, 8'h00);
      chk(7'h0E, e);
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge clk_i) rdd <= rd;
  always @(negedge clk_i) if (rdd) cmp(rdat, q.pop_front());
  always @(posedge clk_i) if (rd || wr) cmp({7'h00, hit}, {7'h00, a >= 7'h0E && a <= 7'h11});
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(7'h0F, 8'h00);
    chk(7'h0E, 8'h64);
    chk(7'h11, 8'hD1);
    chk(7'h10, 8'h20);
    chk(7'h12, 8'h00);
    host.acc(1'b0, 7'h0E, 8'h55);
    host.acc(1'b0, 7'h10, 8'h00);
    chk(7'h11, 8'hD1);
    host.acc(1'b0, 7'h11, 8'hF0);
    chk(7'h10, 8'h00);
    $display("register test done");
    wfe;
    wfe;
    cmp(i[15:8], 8'h0F);
    cmp(i[7:0], 8'hFF);
    agc(6'h3C, 6'h14, 8'h5E);
    agc(6'h28, 6'h14, 8'h63);
    agc(6'h34, 6'h35, 8'h5D);
    cmp(dd & 8'h80, 8'h80);
    for (i = 0; i < 6; i = i + 1) begin
      px = 7'($random(seed));
      pv = 1'b1;
      @(negedge clk_i) pv = 1'b0;
      cmp(dd, {2'b00, (px > 7'h3F) ? 6'h3F : px[5:0]});
    end
    // period 0xF4C0 gives 2880 cycles per frame, so the cap is 0x0040
    host.acc(1'b0, 7'h10, 8'hC0);
    host.acc(1'b0, 7'h11, 8'hF4);
    chk(7'h0F, 8'h00);
    chk(7'h0E, 8'h40);
    @(negedge clk_i);
    cmp(ex[7:0], 8'h40);
    $display("frame, agc and dump test done");
    results;
  end
  // tests need about 29000 cycles; allow roughly twice that
  initial begin
    #300000;
    mismatches = mismatches + 1;
    results;
  end
endmodule
